// *** rtl/jtb_boundary_scan.sv ***
`timescale 1ns/1ps
module jtb_boundary_scan #(
   parameter logic [jtb_pkg::ID_W-1:0] ID_CODE = jtb_pkg::ID_VALUE
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   input wire logic [jtb_pkg::BSR_LEN-1:0] pin_in,
   input wire logic [jtb_pkg::BSR_LEN-1:0] core_drive_in,
   output logic [jtb_pkg::BSR_LEN-1:0] pad_drive_out,
   output logic test_mode_out
);
   localparam int LEN = jtb_pkg::BSR_LEN;
   localparam int IRW = jtb_pkg::IR_W;
   localparam int IDW = jtb_pkg::ID_W;

   if (ID_CODE[0] != 1'b1)
   begin : g_chk
      $error("jtb_boundary_scan: identification code must end in one");
   end

   jtb_tap_if tap ();

   logic [IRW-1:0] ir_shift_reg;
   logic [IRW-1:0] ir_shift_next;
   logic [IRW-1:0] ir_reg;
   logic [LEN-1:0] bsr_shift_reg;
   logic [LEN-1:0] bsr_shift_next;
   logic [LEN-1:0] bsr_latch_reg;
   logic [IDW-1:0] id_shift_reg;
   logic [IDW-1:0] id_shift_next;
   logic byp_reg;
   logic byp_next;
   logic tdo_reg;
   logic tdo_oe_reg;
   logic upd_tgl_reg;
   logic test_en_reg;
   logic [LEN-1:0] pin_sync;
   logic [LEN-1:0] cell_capture;
   logic [1:0] xfer_sync;
   logic tgl_seen_reg;
   logic [LEN-1:0] out_word_reg;
   logic [LEN-1:0] pad_reg;
   logic [LEN-1:0] pad_next;

   // Controller
   jtb_tap_fsm u_fsm (
      .tck_in(tck_in),
      .rst_in(sys_rst_in),
      .tms_in(tms_in),
      .tap(tap.fsm)
   );

   // Pin levels brought into the TCK domain
   jtb_sync #(.W(LEN)) u_pin_sync (
      .clk_in(tck_in),
      .rst_in(sys_rst_in),
      .d_in(pin_in),
      .q_out(pin_sync)
   );

   // Register selection by current instruction
   wire sel_bsr = (ir_reg == jtb_pkg::INS_EXTEST) ||
                  (ir_reg == jtb_pkg::INS_SAMPLE);
   wire sel_id = (ir_reg == jtb_pkg::INS_IDCODE);
   wire sel_byp = !sel_bsr && !sel_id;

   // Constant cells ignore the pins
   assign cell_capture = (pin_sync & ~jtb_pkg::CONST_MASK) |
                         jtb_pkg::CONST_HIGH_MASK;

   // Instruction shift path
   always_comb
   begin
      ir_shift_next = ir_shift_reg;
      if (tap.capture_ir)
         ir_shift_next = jtb_pkg::IR_CAPTURE;
      else if (tap.shift_ir)
         ir_shift_next = {tdi_in, ir_shift_reg[IRW-1:1]};
   end

   // Boundary shift path
   always_comb
   begin
      bsr_shift_next = bsr_shift_reg;
      if (tap.capture_dr && sel_bsr)
         bsr_shift_next = cell_capture;
      else if (tap.shift_dr && sel_bsr)
         bsr_shift_next = {tdi_in, bsr_shift_reg[LEN-1:1]};
   end

   // Identification shift path
   always_comb
   begin
      id_shift_next = id_shift_reg;
      if (tap.capture_dr && sel_id)
         id_shift_next = ID_CODE;
      else if (tap.shift_dr && sel_id)
         id_shift_next = {tdi_in, id_shift_reg[IDW-1:1]};
   end

   // Bypass stage
   always_comb
   begin
      byp_next = byp_reg;
      if (tap.capture_dr && sel_byp)
         byp_next = 1'b0;
      else if (tap.shift_dr && sel_byp)
         byp_next = tdi_in;
   end

   // Serial output source
   wire dr_serial = sel_bsr ? bsr_shift_reg[0] :
                    sel_id ? id_shift_reg[0] : byp_reg;
   wire tdo_next = tap.shift_ir ? ir_shift_reg[0] : dr_serial;
   wire tdo_en_next = tap.shift_ir || tap.shift_dr;

   // Rising-edge shift stages; all other states hold
   always_ff @(posedge tck_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ir_shift_reg <= jtb_pkg::IR_CAPTURE;
         bsr_shift_reg <= '0;
         id_shift_reg <= '0;
         byp_reg <= 1'b0;
      end
      else
      begin
         ir_shift_reg <= ir_shift_next;
         bsr_shift_reg <= bsr_shift_next;
         id_shift_reg <= id_shift_next;
         byp_reg <= byp_next;
      end
   end

   // Falling-edge instruction and serial output
   always_ff @(negedge tck_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ir_reg <= jtb_pkg::INS_IDCODE;
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end
      else
      begin
         if (tap.in_reset)
            ir_reg <= jtb_pkg::INS_IDCODE;
         else if (tap.update_ir)
            ir_reg <= ir_shift_reg;
         tdo_reg <= tdo_next;
         tdo_oe_reg <= tdo_en_next;
      end
   end

   // Falling-edge parallel latch and hand-off toggle
   always_ff @(negedge tck_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         bsr_latch_reg <= '0;
         upd_tgl_reg <= 1'b0;
         test_en_reg <= 1'b0;
      end
      else
      begin
         if (tap.update_dr && sel_bsr)
         begin
            bsr_latch_reg <= bsr_shift_reg;
            upd_tgl_reg <= !upd_tgl_reg;
         end
         test_en_reg <= !tap.in_reset &&
                        (ir_reg == jtb_pkg::INS_EXTEST);
      end
   end

   assign tdo_out = tdo_reg;
   assign tdo_oe_out = tdo_oe_reg;

   // Toggle and test enable into the system clock domain
   jtb_sync #(.W(2)) u_xfer (
      .clk_in(clk_in),
      .rst_in(sys_rst_in),
      .d_in({upd_tgl_reg, test_en_reg}),
      .q_out(xfer_sync)
   );

   // Latched word is stable for several TCK periods after a toggle
   wire new_word = (xfer_sync[1] != tgl_seen_reg);
   assign pad_next = xfer_sync[0] ? out_word_reg : core_drive_in;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         tgl_seen_reg <= 1'b0;
         out_word_reg <= '0;
         pad_reg <= '0;
      end
      else
      begin
         tgl_seen_reg <= xfer_sync[1];
         if (new_word)
            out_word_reg <= bsr_latch_reg;
         pad_reg <= pad_next;
      end
   end

   assign pad_drive_out = pad_reg;
   assign test_mode_out = xfer_sync[0];

   AST_MISSION: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !xfer_sync[0] |=> pad_drive_out == $past(core_drive_in))
      else $error("pads not following mission data");

   AST_IR_CAPTURE: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.capture_ir |=> ir_shift_reg == jtb_pkg::IR_CAPTURE)
      else $error("instruction capture pattern wrong");

   AST_CONST_CELLS: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.capture_dr && sel_bsr |=>
      (bsr_shift_reg & jtb_pkg::CONST_MASK) == jtb_pkg::CONST_HIGH_MASK)
      else $error("constant cells captured wrong value");

   AST_PIN_CAPTURE: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.capture_dr && sel_bsr |=>
      (bsr_shift_reg & ~jtb_pkg::CONST_MASK) ==
      ($past(pin_sync) & ~jtb_pkg::CONST_MASK))
      else $error("pin values not captured");

   AST_BSR_SHIFT: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.shift_dr && sel_bsr |=>
      bsr_shift_reg[LEN-1] == $past(tdi_in) &&
      bsr_shift_reg[LEN-2:0] == $past(bsr_shift_reg[LEN-1:1]))
      else $error("boundary shift wrong");

   AST_IDLE_KEEP: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.st == jtb_pkg::ST_IDLE |=> $stable(bsr_shift_reg))
      else $error("boundary register changed in idle");

   AST_IDCODE_LOAD: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      tap.in_reset |=> ir_reg == jtb_pkg::INS_IDCODE)
      else $error("reset state did not load identification");

   AST_UPD_ONLY: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      $changed(bsr_latch_reg) |-> $past(tap.update_dr))
      else $error("parallel latch changed outside update");

   AST_IR_UPDATE: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      tap.update_ir |=> ir_reg == $past(ir_shift_reg))
      else $error("instruction not latched on update");

   AST_SEL_KEEP: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.st == jtb_pkg::ST_SEL_DR |=>
      $stable(bsr_shift_reg) && $stable(id_shift_reg) && $stable(byp_reg))
      else $error("data register changed in select state");

   AST_CAP_IR_KEEP: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      tap.capture_dr |=> $stable(ir_reg))
      else $error("instruction changed during data capture");

   AST_SHIFT_IR_KEEP: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      tap.shift_dr |=> $stable(ir_reg))
      else $error("instruction changed during data shift");

   AST_TDO_ENABLE: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      tap.shift_dr |=> tdo_oe_out)
      else $error("serial output not driven in shift");

   AST_DR_SERIAL: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      tap.shift_dr && sel_bsr |=> tdo_out == $past(bsr_shift_reg[0]))
      else $error("serial output not boundary stage zero");

   AST_IR_SHIFT: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.shift_ir |=>
      ir_shift_reg == {$past(tdi_in), $past(ir_shift_reg[IRW-1:1])})
      else $error("instruction shift wrong");

   AST_IR_SERIAL: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      tap.shift_ir |=> tdo_out == $past(ir_shift_reg[0]))
      else $error("serial output not instruction stage zero");

   AST_PAUSE_KEEP: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.st == jtb_pkg::ST_PAU_DR |=>
      $stable(bsr_shift_reg) && $stable(id_shift_reg) && $stable(byp_reg))
      else $error("data register changed in pause");

   AST_UPD_DR_KEEP: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.update_dr |=> $stable(bsr_shift_reg))
      else $error("boundary stages changed in update");

   AST_UPD_IR_KEEP: assert property (
      @(posedge tck_in) disable iff (sys_rst_in)
      tap.update_ir |=>
      $stable(bsr_shift_reg) && $stable(id_shift_reg) && $stable(byp_reg))
      else $error("data register changed in instruction update");

   AST_RESET_SAFE: assert property (
      @(negedge tck_in) disable iff (sys_rst_in)
      tap.in_reset |=> !test_en_reg && !tdo_oe_out)
      else $error("test logic active in reset state");

   AST_TEST_PADS: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      xfer_sync[0] |=> pad_drive_out == $past(out_word_reg))
      else $error("pads not showing latched boundary word");
endmodule

// *** rtl/jtb_pkg.sv ***
package jtb_pkg;

   // Controller states
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
      ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
      ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } jtb_state_t;

   // Instruction register
   localparam int IR_W = 3;
   localparam logic [IR_W-1:0] IR_CAPTURE = 3'h4;
   localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPLE = 3'h2;
   localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

   // Identification register, value arbitrary
   localparam int ID_W = 32;
   localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5c_3001;

   // Boundary register layout
   localparam int BSR_LEN = 99;
   localparam logic [BSR_LEN-1:0] BIT1 = 99'h1;
   localparam logic [BSR_LEN-1:0] CONST_LOW_MASK =
      (BIT1 << 58) | (BIT1 << 59) | (BIT1 << 60) | (BIT1 << 66) |
      (BIT1 << 67) | (BIT1 << 68) | (BIT1 << 81) | (BIT1 << 82) |
      (BIT1 << 83) | (BIT1 << 89) | (BIT1 << 90) | (BIT1 << 91);
   localparam logic [BSR_LEN-1:0] CONST_HIGH_MASK =
      (BIT1 << 64) | (BIT1 << 72) | (BIT1 << 79) | (BIT1 << 87);
   localparam logic [BSR_LEN-1:0] CONST_MASK =
      CONST_LOW_MASK | CONST_HIGH_MASK;

endpackage

// *** rtl/jtb_sync.sv ***
`timescale 1ns/1ps
module jtb_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;

   if (W < 1)
   begin : g_chk
      $error("jtb_sync: width must be at least one");
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end
      else
      begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change counts once stages two and three agree
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk_in)
      begin
         if (rst_in)
            q_reg[i] <= 1'b0;
         else if (s2_reg[i] == s3_reg[i])
            q_reg[i] <= s3_reg[i];
      end
   end

   assign q_out = q_reg;
endmodule

// *** rtl/jtb_tap_fsm.sv ***
`timescale 1ns/1ps
module jtb_tap_fsm (
   input wire logic tck_in,
   input wire logic rst_in,
   input wire logic tms_in,
   jtb_tap_if.fsm tap
);
   jtb_pkg::jtb_state_t st_reg;
   jtb_pkg::jtb_state_t st_next;

   // Power-up reset lands in the reset state with no TCK needed
   always_ff @(posedge tck_in or posedge rst_in)
   begin
      if (rst_in)
         st_reg <= jtb_pkg::ST_RESET;
      else
         st_reg <= st_next;
   end

   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         jtb_pkg::ST_RESET:
            st_next = tms_in ? jtb_pkg::ST_RESET : jtb_pkg::ST_IDLE;
         jtb_pkg::ST_IDLE:
            st_next = tms_in ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
         jtb_pkg::ST_SEL_DR:
            st_next = tms_in ? jtb_pkg::ST_SEL_IR : jtb_pkg::ST_CAP_DR;
         jtb_pkg::ST_CAP_DR:
            st_next = tms_in ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_SH_DR:
            st_next = tms_in ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_EX1_DR:
            st_next = tms_in ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_PAU_DR;
         jtb_pkg::ST_PAU_DR:
            st_next = tms_in ? jtb_pkg::ST_EX2_DR : jtb_pkg::ST_PAU_DR;
         jtb_pkg::ST_EX2_DR:
            st_next = tms_in ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_UPD_DR:
            st_next = tms_in ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
         jtb_pkg::ST_SEL_IR:
            st_next = tms_in ? jtb_pkg::ST_RESET : jtb_pkg::ST_CAP_IR;
         jtb_pkg::ST_CAP_IR:
            st_next = tms_in ? jtb_pkg::ST_EX1_IR : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_SH_IR:
            st_next = tms_in ? jtb_pkg::ST_EX1_IR : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_EX1_IR:
            st_next = tms_in ? jtb_pkg::ST_UPD_IR : jtb_pkg::ST_PAU_IR;
         jtb_pkg::ST_PAU_IR:
            st_next = tms_in ? jtb_pkg::ST_EX2_IR : jtb_pkg::ST_PAU_IR;
         jtb_pkg::ST_EX2_IR:
            st_next = tms_in ? jtb_pkg::ST_UPD_IR : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_UPD_IR:
            st_next = tms_in ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
         default:
            st_next = jtb_pkg::ST_RESET;
      endcase
   end

   assign tap.st = st_reg;
   assign tap.in_reset = (st_reg == jtb_pkg::ST_RESET);
   assign tap.capture_dr = (st_reg == jtb_pkg::ST_CAP_DR);
   assign tap.shift_dr = (st_reg == jtb_pkg::ST_SH_DR);
   assign tap.update_dr = (st_reg == jtb_pkg::ST_UPD_DR);
   assign tap.capture_ir = (st_reg == jtb_pkg::ST_CAP_IR);
   assign tap.shift_ir = (st_reg == jtb_pkg::ST_SH_IR);
   assign tap.update_ir = (st_reg == jtb_pkg::ST_UPD_IR);

   AST_FIVE_HIGH: assert property (
      @(posedge tck_in) disable iff (rst_in)
      tms_in [*5] |=> st_reg == jtb_pkg::ST_RESET)
      else $error("five TMS-high edges did not reach reset");

   AST_IDLE_HOLD: assert property (
      @(posedge tck_in) disable iff (rst_in)
      st_reg == jtb_pkg::ST_IDLE |=>
      st_reg == ($past(tms_in) ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE))
      else $error("idle state left wrongly");

   AST_SEL_DR: assert property (
      @(posedge tck_in) disable iff (rst_in)
      st_reg == jtb_pkg::ST_SEL_DR && !tms_in |=>
      st_reg == jtb_pkg::ST_CAP_DR ##1
      (st_reg == jtb_pkg::ST_SH_DR || st_reg == jtb_pkg::ST_EX1_DR))
      else $error("data scan did not start from select");

   AST_CAP_DR: assert property (
      @(posedge tck_in) disable iff (rst_in)
      st_reg == jtb_pkg::ST_CAP_DR |=>
      st_reg == ($past(tms_in) ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR))
      else $error("capture exit wrong");

   AST_SH_DR: assert property (
      @(posedge tck_in) disable iff (rst_in)
      st_reg == jtb_pkg::ST_SH_DR && !tms_in [*3] |=>
      st_reg == jtb_pkg::ST_SH_DR)
      else $error("shift state left with TMS low");

   AST_EX1_DR: assert property (
      @(posedge tck_in) disable iff (rst_in)
      st_reg == jtb_pkg::ST_EX1_DR |=>
      st_reg == ($past(tms_in) ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_PAU_DR))
      else $error("exit1 data exit wrong");

   AST_IR_MIRROR: assert property (
      @(posedge tck_in) disable iff (rst_in)
      st_reg == jtb_pkg::ST_EX2_IR && !tms_in |=>
      st_reg == jtb_pkg::ST_SH_IR)
      else $error("instruction branch does not mirror data branch");
endmodule

// *** rtl/jtb_tap_if.sv ***
`timescale 1ns/1ps
interface jtb_tap_if;
   jtb_pkg::jtb_state_t st;
   logic in_reset;
   logic capture_dr;
   logic shift_dr;
   logic update_dr;
   logic capture_ir;
   logic shift_ir;
   logic update_ir;

   modport fsm (output st, in_reset, capture_dr, shift_dr, update_dr,
                capture_ir, shift_ir, update_ir);
   modport core (input st, in_reset, capture_dr, shift_dr, update_dr,
                 capture_ir, shift_ir, update_ir);
endinterface

// *** testbench/jtb_tester.sv ***
`timescale 1ns/1ps
module jtb_tester (
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   input wire logic tdo_in
);
   initial
   begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end

   // One TCK period; clock rests low between calls, TDO read before rise
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      tms_out = tms;
      tdi_out = tdi;
      #83;
      tdo = tdo_in;
      tck_out = 1'b1;
      #77;
      tck_out = 1'b0;
   endtask

   // Five TMS-high periods force the reset state from anywhere
   task automatic force_reset();
      logic d;
      repeat (5) tick(1'b1, ~tdi_out, d);
   endtask
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   localparam int N = jtb_pkg::BSR_LEN;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b0;
   logic [N-1:0] pin_in = '0;
   logic [N-1:0] core_drive_in = '0;
   logic tck, tms, tdi, tdo, tdo_oe, test_mode;
   logic [N-1:0] pad;
   logic [15:0] seed = 16'h7093;
   int fail_count = 0;
   int n_checks = 0;

   always #5 clk_in = ~clk_in;

   jtb_boundary_scan dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck),
      .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
      .pin_in(pin_in), .core_drive_in(core_drive_in),
      .pad_drive_out(pad), .test_mode_out(test_mode)
   );

   jtb_tester tester (
      .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo)
   );

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic rnd(output logic [N-1:0] v);
      v = '0;
      repeat (7)
      begin
         seed = lfsr(seed);
         v = {v[N-17:0], seed};
      end
   endtask

   // Constant cells override the pins; reserved cells left out
   function automatic logic [N-1:0] cap_exp(input logic [N-1:0] p);
      return ((p & ~jtb_pkg::CONST_MASK) | jtb_pkg::CONST_HIGH_MASK) &
             keep();
   endfunction

   // Reserved output cells are left out of comparisons
   function automatic logic [N-1:0] keep();
      logic [N-1:0] m;
      m = '0;
      for (int i = 61; i <= 91; i++) m[i] = 1'b1;
      m[74] = 1'b0;
      m[75] = 1'b0;
      return ~(m & ~jtb_pkg::CONST_MASK);
   endfunction

   task automatic chk(input string what, input logic [N-1:0] seen,
                      input logic [N-1:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic step(input logic t);
      logic d;
      tester.tick(t, ~tdi, d);
   endtask

   // Pads cross into the system clock a few cycles after an update
   task automatic wait_pad(input logic [N-1:0] exp);
      for (int i = 0; i < 20 && pad !== exp; i++) @(posedge clk_in);
      #1;
      chk("pad_drive", pad, exp);
   endtask

   // Full scan from Idle back to Idle, optional pause before update
   task automatic scan(input logic ir, input int n, input logic [N-1:0] din,
                       input logic [N-1:0] pad_exp, input logic pause,
                       output logic [N-1:0] dout);
      logic b;
      dout = '0;
      step(1'b1);
      if (ir)
         step(1'b1);
      step(1'b0);
      step(1'b0);
      #1;
      chk("tdo_enable", tdo_oe, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         tester.tick(i == n - 1, din[i], b);
         dout[i] = b;
      end
      if (pause)
      begin
         step(1'b0);
         step(1'b0);
         chk("pad_hold", pad, pad_exp);
         step(1'b1);
      end
      step(1'b1);
      step(1'b0);
   endtask

   initial
   begin
      logic [N-1:0] a, b, c, d, p;
      sys_rst_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rnd(p);
      rnd(d);
      pin_in <= p;
      core_drive_in <= d;
      repeat (3) @(posedge clk_in);
      #1;
      chk("pad_mission", pad, d);
      chk("test_mode", test_mode, 1'b0);
      repeat (3) step(1'b0);
      scan(1'b0, 32, '0, d, 1'b0, a);
      chk("idcode", a[31:0], jtb_pkg::ID_VALUE);
      scan(1'b1, 3, jtb_pkg::INS_SAMPLE, d, 1'b1, a);
      chk("ir_capture", a[2:0], jtb_pkg::IR_CAPTURE);
      rnd(b);
      scan(1'b0, N, b, d, 1'b0, a);
      chk("bsr_cap", a & keep(), cap_exp(p));
      wait_pad(d);
      scan(1'b1, 3, jtb_pkg::INS_EXTEST, d, 1'b0, a);
      wait_pad(b);
      chk("test_mode", test_mode, 1'b1);
      @(posedge clk_in);
      rnd(p);
      pin_in <= p;
      repeat (4) step(1'b0);
      rnd(c);
      scan(1'b0, N, c, b, 1'b1, a);
      chk("bsr_extest", a & keep(), cap_exp(p));
      wait_pad(c);
      scan(1'b1, 3, jtb_pkg::INS_BYPASS, c, 1'b0, a);
      scan(1'b0, 2, 'h1, c, 1'b0, a);
      chk("bypass", a[1:0], 2'h2);
      step(1'b1);
      step(1'b0);
      step(1'b0);
      tester.force_reset();
      wait_pad(d);
      chk("test_mode", test_mode, 1'b0);
      step(1'b0);
      scan(1'b0, 32, '0, d, 1'b0, a);
      chk("idcode", a[31:0], jtb_pkg::ID_VALUE);
      wrap_up();
   end

   // Whole sequence needs roughly 55 us of test clock
   initial
   begin
      #500000;
      fail_count++;
      wrap_up();
   end
endmodule
